/* operating_mode_select.sv */
// Added by the designer: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Straps pick normal/special and bus width
// - Straps latched into mode bits at reset release
// - Mode bits readable, limited run-time switching
// - Expanded: unclaimed addresses go external
// - Normal single chip: no external bus
// - Wide: 16-bit muxed bus on ports A,B
// - Narrow: 16-bit address, data on A
// - Narrow word: high byte then low byte
// - Second narrow byte uses incremented address
// - Special single chip: debug active from reset
// - Normal: debug needs enable then activate
// - Peripheral: processor idle, external master drives
// - Peripheral mode entered/left only through reset
// - Normal modes protect control bits
// - Special modes relax control bit protection
// - Expanded/peripheral: ports A,B registers unmapped
// - Port E registers unmapped per emulation bit
// - Port K registers unmapped per emulation bit
// - Special bit writable in special, first ignored
// - Select bits: once normal, any write after the first in special, never code 10
// - Stretch enable shapes bus clock
// - Visibility shows internal cycles, not single chip
module operating_mode_select #(
   parameter int unsigned DATA_CYCLES = op_mode_pkg::DATA_PHASE_CYCLES
) (
   input wire logic clock,
   input wire logic srst,
   input wire logic debugStrapPin,
   input wire logic modeSelectHiPin,
   input wire logic modeSelectLoPin,
   input wire logic [op_mode_pkg::REG_ADDR_W-1:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [7:0] regRdData,
   input wire logic bgDebugEnableCmd,
   input wire logic bgDebugActivateCmd,
   input wire logic bgDebugExitCmd,
   input wire op_mode_pkg::ext_req_t accReq,
   input wire logic accValid,
   output logic accReady,
   output logic accDone,
   output logic [15:0] accRdData,
   input wire logic [7:0] portAIn,
   input wire logic [7:0] portBIn,
   output logic [7:0] portAOut,
   output logic [7:0] portBOut,
   output logic portADriveN,
   output logic portBDriveN,
   output logic addrPhase,
   output logic extRead,
   output logic eClock,
   output logic cpuActive,
   output logic protectRelaxed,
   output logic bgDebugEnabled,
   output logic bgDebugActive,
   output logic singleChip,
   output logic narrowBus,
   output logic wideBus,
   output logic peripheralMode,
   output logic portAbInMap,
   output logic portEInMap,
   output logic portKInMap,
   output logic extBusStopInWait
);
   import op_mode_pkg::*;

   localparam logic [1:0] CNT_LAST = 2'(DATA_CYCLES - 1);

   // Straps and port inputs arrive from pins
   logic [2:0] strapMeta;
   logic [2:0] strapSync;
   logic [7:0] portAMeta;
   logic [7:0] portBMeta;
   logic [7:0] portASync;
   logic [7:0] portBSync;

   mode_reg_t opMode;
   mode_reg_t next_opMode;
   logic firstWriteDone;
   logic eToggle;
   bus_state_t state;
   bus_state_t next_state;
   ext_req_t curReq;
   logic [1:0] dataCnt;

   always_ff @(posedge clock) begin
      strapMeta <= {debugStrapPin, modeSelectHiPin, modeSelectLoPin};
      strapSync <= strapMeta;
      portAMeta <= portAIn;
      portBMeta <= portBIn;
      portASync <= portAMeta;
      portBSync <= portBMeta;
   end

   // Mode decode
   wire [1:0] modeSel = {opMode.modeSelectHi, opMode.modeSelectLo};
   wire special = !opMode.specialModeN;
   assign singleChip = modeSel == SEL_SINGLE;
   assign narrowBus = modeSel == SEL_NARROW;
   assign wideBus = modeSel == SEL_WIDE;
   assign peripheralMode = special && modeSel == SEL_PERIPH;
   wire expandedMode = narrowBus || wideBus;
   assign cpuActive = !peripheralMode;
   assign protectRelaxed = special;
   assign extBusStopInWait = opMode.extBusStopInWait;

   // Register map presence of the port registers
   assign portAbInMap = singleChip;
   assign portEInMap = !(peripheralMode || (expandedMode && opMode.portEEmulationEn));
   assign portKInMap = !(peripheralMode || (expandedMode && opMode.portKEmulationEn));

   // Strap capture; reserved combination becomes peripheral
   wire strapReserved = strapSync == STRAP_RESERVED;
   wire [2:0] strapMode = strapReserved ? STRAP_FORCED_PERIPH : strapSync;
   wire [4:0] strapOpts = strapMode[2] ? OPT_RESET_NORMAL : OPT_RESET_SPECIAL;

   // Register writes; the block is absent in peripheral mode
   wire ctrlSel = regAddr == OPMODE_CTRL_OFFSET;
   wire ctrlMapped = !peripheralMode;
   wire ctrlWr = regWr && ctrlSel && ctrlMapped;
   wire [1:0] wrSel = regWrData[BIT_SEL_HI:BIT_SEL_LO];
   wire selLegal = wrSel != SEL_PERIPH;
   wire specialAfterFirst = special && firstWriteDone;
   wire normalOnce = !special && !firstWriteDone;
   wire wrSpecialN = ctrlWr && specialAfterFirst;
   wire wrSelect = ctrlWr && selLegal && (specialAfterFirst || normalOnce);
   wire wrStretch = ctrlWr && (special || normalOnce);
   wire wrOnceOpts = ctrlWr && (specialAfterFirst || normalOnce);
   wire wrStopWait = ctrlWr && !special;

   always_comb begin
      next_opMode = opMode;
      // Software can leave special modes but never return to them
      if (wrSpecialN) begin
         next_opMode.specialModeN = regWrData[BIT_SPECIAL_N];
      end
      if (wrSelect) begin
         next_opMode.modeSelectHi = regWrData[BIT_SEL_HI];
         next_opMode.modeSelectLo = regWrData[BIT_SEL_LO];
      end
      if (wrStretch) begin
         next_opMode.busClockStretchEn = regWrData[BIT_STRETCH];
      end
      if (wrOnceOpts) begin
         next_opMode.internalVisibilityEn = regWrData[BIT_VISIBLE];
         next_opMode.portKEmulationEn = regWrData[BIT_EMU_K];
         next_opMode.portEEmulationEn = regWrData[BIT_EMU_E];
      end
      if (wrStopWait) begin
         next_opMode.extBusStopInWait = regWrData[BIT_STOP_WAIT];
      end
   end

   // Held in reset, the register tracks the straps; release freezes them
   always_ff @(posedge clock) begin
      if (srst) begin
         opMode <= mode_reg_t'({strapMode, strapOpts});
         firstWriteDone <= 1'b0;
      end else begin
         opMode <= next_opMode;
         firstWriteDone <= firstWriteDone | ctrlWr;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         regRdData <= 8'h00;
      end else begin
         regRdData <= (regRd && ctrlSel && ctrlMapped) ? opMode : 8'h00;
      end
   end

   // Background debug; set wins over exit in the same cycle
   wire strapDebugNow = strapMode == STRAP_SPECIAL_SINGLE;
   wire debugActivate = bgDebugActivateCmd && bgDebugEnabled && !peripheralMode;

   always_ff @(posedge clock) begin
      if (srst) begin
         bgDebugEnabled <= strapDebugNow;
         bgDebugActive <= strapDebugNow;
      end else begin
         bgDebugEnabled <= bgDebugEnabled | bgDebugEnableCmd;
         bgDebugActive <= debugActivate | (bgDebugActive & !bgDebugExitCmd);
      end
   end

   // External bus engine
   wire visibilityOn = opMode.internalVisibilityEn && expandedMode;
   wire runBus = expandedMode && (!accReq.internalHit || visibilityOn);
   assign accReady = state == BUS_IDLE && cpuActive;
   wire accept = accValid && accReady;
   wire curWideData = wideBus || curReq.internalHit;
   wire twoBeat = narrowBus && curReq.word && !curReq.internalHit;
   wire cntEnd = dataCnt == CNT_LAST;
   wire dataPhase = state == BUS_DATA_HI || state == BUS_DATA_LO;
   wire lastBeatEnd = cntEnd && (state == BUS_DATA_LO || (state == BUS_DATA_HI && !twoBeat));
   wire takeRead = !curReq.write && !curReq.internalHit;

   always_comb begin
      next_state = state;
      case (state)
         BUS_IDLE: begin
            if (accept && runBus) begin
               next_state = BUS_ADDR_HI;
            end
         end
         BUS_ADDR_HI: begin
            next_state = BUS_DATA_HI;
         end
         BUS_DATA_HI: begin
            if (cntEnd) begin
               next_state = twoBeat ? BUS_ADDR_LO : BUS_IDLE;
            end
         end
         BUS_ADDR_LO: begin
            next_state = BUS_DATA_LO;
         end
         BUS_DATA_LO: begin
            if (cntEnd) begin
               next_state = BUS_IDLE;
            end
         end
         default: begin
            next_state = BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         state <= BUS_IDLE;
         dataCnt <= 2'h0;
      end else begin
         state <= next_state;
         dataCnt <= (dataPhase && !cntEnd) ? dataCnt + 2'h1 : 2'h0;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         curReq <= '0;
      end else if (accept) begin
         curReq <= accReq;
      end
   end

   // Read capture; narrow words fill high byte first
   wire [7:0] wideByteLane = curReq.addr[0] ? portBSync : portASync;
   wire [15:0] hiCapture = curWideData ?
      (curReq.word ? {portASync, portBSync} : {8'h00, wideByteLane}) :
      (curReq.word ? {portASync, accRdData[7:0]} : {8'h00, portASync});

   always_ff @(posedge clock) begin
      if (srst) begin
         accRdData <= 16'h0000;
      end else if (cntEnd && takeRead && state == BUS_DATA_HI) begin
         accRdData <= hiCapture;
      end else if (cntEnd && takeRead && state == BUS_DATA_LO) begin
         accRdData <= {accRdData[15:8], portASync};
      end
   end

   // Requests that need no bus finish one cycle after acceptance
   always_ff @(posedge clock) begin
      if (srst) begin
         accDone <= 1'b0;
      end else begin
         accDone <= (accept && !runBus) || lastBeatEnd;
      end
   end

   // Pin muxing
   wire loBeat = state == BUS_ADDR_LO || state == BUS_DATA_LO;
   wire [15:0] busAddr = loBeat ? curReq.addr + 16'h0001 : curReq.addr;
   wire [7:0] narrowByte = (state == BUS_DATA_HI && curReq.word) ?
      curReq.wrData[15:8] : curReq.wrData[7:0];
   wire [7:0] wideHiByte = curReq.word ? curReq.wrData[15:8] : curReq.wrData[7:0];
   wire [7:0] dataA = curWideData ? wideHiByte : narrowByte;
   wire [7:0] dataB = curWideData ? curReq.wrData[7:0] : busAddr[7:0];
   wire busy = state != BUS_IDLE;

   assign addrPhase = state == BUS_ADDR_HI || state == BUS_ADDR_LO;
   assign portAOut = addrPhase ? busAddr[15:8] : dataA;
   assign portBOut = addrPhase ? busAddr[7:0] : dataB;
   assign portADriveN = !(addrPhase || (dataPhase && curReq.write));
   assign portBDriveN = !(addrPhase || (dataPhase && (curReq.write || !curWideData)));
   assign extRead = busy ? !curReq.write : 1'b1;

   // Stretching is forced in expanded modes for address demultiplexing
   wire stretchOn = opMode.busClockStretchEn || expandedMode;

   always_ff @(posedge clock) begin
      if (srst) begin
         eToggle <= 1'b0;
      end else begin
         eToggle <= !eToggle;
      end
   end

   assign eClock = stretchOn ? busy : eToggle;

   // Checks
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (srst);

   a_strap_capture: assert property (
      $fell(srst) && $past(strapSync) != STRAP_RESERVED |->
         {opMode.specialModeN, modeSel} == $past(strapSync))
      else $error("Mode bits differ from straps at reset release");

   a_reserved_forced: assert property (
      $fell(srst) && $past(strapSync) == STRAP_RESERVED |-> peripheralMode)
      else $error("Reserved strap not forced to peripheral");

   a_periph_locked: assert property (
      !$past(srst) |-> peripheralMode == $past(peripheralMode))
      else $error("Peripheral mode changed without reset");

   a_special_guard: assert property (
      regWr && ctrlSel && (opMode.specialModeN || !firstWriteDone) |=>
         $stable(opMode.specialModeN))
      else $error("Special bit changed by a refused write");

   a_select_once: assert property (
      regWr && ctrlSel && !special && firstWriteDone |=> $stable(modeSel))
      else $error("Normal mode select written twice");

   a_debug_reset: assert property (
      $fell(srst) && $past(strapSync) == STRAP_SPECIAL_SINGLE |-> bgDebugActive)
      else $error("Debug not active after special single chip reset");

   a_debug_enable: assert property (
      !$past(srst) && $rose(bgDebugActive) |-> $past(bgDebugEnabled))
      else $error("Debug activated without enable");

   a_narrow_incr: assert property (
      state == BUS_ADDR_LO |-> {portAOut, portBOut} == curReq.addr + 16'h0001)
      else $error("Second narrow byte address not incremented");

   a_narrow_order: assert property (
      state == BUS_DATA_HI && cntEnd && twoBeat |=> state == BUS_ADDR_LO ##1
         state == BUS_DATA_LO)
      else $error("Narrow word beats out of order");

   a_single_nobus: assert property (
      singleChip |-> portADriveN && portBDriveN && !busy)
      else $error("Bus driven in single chip mode");

   a_ext_route: assert property (
      accept && expandedMode && !accReq.internalHit |=> state == BUS_ADDR_HI)
      else $error("Unclaimed address not sent external");

   a_eclock_stretch: assert property (
      stretchOn |-> eClock == busy)
      else $error("Stretched bus clock wrong");

   a_ports_unmapped: assert property (
      !singleChip |-> !portAbInMap)
      else $error("Port A/B registers mapped outside single chip");

   c_narrow_word: cover property (
      state == BUS_DATA_LO && cntEnd && takeRead);
   c_special_single: cover property (
      $fell(srst) && bgDebugActive);
   c_leave_special: cover property (
      special ##1 !special);

endmodule : operating_mode_select

`default_nettype wire

/* op_mode_pkg.sv */
package op_mode_pkg;

   // Register slave geometry; one byte-wide register block
   localparam int unsigned REG_ADDR_W = 10;
   localparam logic [REG_ADDR_W-1:0] OPMODE_CTRL_OFFSET = 10'h00b;

   // Bit positions inside operating_mode_control
   localparam int unsigned BIT_SPECIAL_N = 7;
   localparam int unsigned BIT_SEL_HI = 6;
   localparam int unsigned BIT_SEL_LO = 5;
   localparam int unsigned BIT_STRETCH = 4;
   localparam int unsigned BIT_VISIBLE = 3;
   localparam int unsigned BIT_STOP_WAIT = 2;
   localparam int unsigned BIT_EMU_K = 1;
   localparam int unsigned BIT_EMU_E = 0;

   // Reset values of the five option bits (stretch .. port E emulation)
   localparam logic [4:0] OPT_RESET_SPECIAL = 5'h1b;
   localparam logic [4:0] OPT_RESET_NORMAL = 5'h10;

   // Mode-select pair encodings
   localparam logic [1:0] SEL_SINGLE = 2'h0;
   localparam logic [1:0] SEL_NARROW = 2'h1;
   localparam logic [1:0] SEL_PERIPH = 2'h2;
   localparam logic [1:0] SEL_WIDE = 2'h3;

   // Strap triple {debug, hi, lo}
   localparam logic [2:0] STRAP_RESERVED = 3'h6;
   localparam logic [2:0] STRAP_SPECIAL_SINGLE = 3'h0;
   localparam logic [2:0] STRAP_FORCED_PERIPH = 3'h2;

   // Data phase length in clocks; covers the two-flop pin synchroniser
   localparam int unsigned DATA_PHASE_CYCLES = 3;
   localparam int unsigned BUS_CLOCK_HZ = 40_000_000;

   typedef struct packed {
      logic specialModeN;
      logic modeSelectHi;
      logic modeSelectLo;
      logic busClockStretchEn;
      logic internalVisibilityEn;
      logic extBusStopInWait;
      logic portKEmulationEn;
      logic portEEmulationEn;
   } mode_reg_t;

   typedef struct packed {
      logic [15:0] addr;
      logic [15:0] wrData;
      logic write;
      logic word;
      logic internalHit;
   } ext_req_t;

   typedef enum logic [2:0] {
      BUS_IDLE = 3'h0,
      BUS_ADDR_HI = 3'h1,
      BUS_DATA_HI = 3'h3,
      BUS_ADDR_LO = 3'h2,
      BUS_DATA_LO = 3'h6
   } bus_state_t;

endpackage : op_mode_pkg

/* ext_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model #(
   parameter int unsigned DC = 3
) (
   input wire logic clock,
   input wire logic narrow,
   input wire logic addrPhase,
   input wire logic extRead,
   input wire logic portADriveN,
   input wire logic [7:0] portAOut,
   input wire logic [7:0] portBOut,
   output logic [7:0] portAIn,
   output logic [7:0] portBIn
);
   logic [7:0] mem [256];
   logic [7:0] a;
   int cnt = 0;
   initial begin
      for (int i = 0; i < 256; i++) begin
         mem[i] = 8'(i) ^ 8'h5a;
      end
      portAIn = 8'h00;
      portBIn = 8'h00;
      a = 8'h00;
   end
   // Data stands only for the data phase, then the lanes flip
   always @(posedge clock) begin
      if (addrPhase) begin
         a <= portBOut;
         cnt <= DC;
         portAIn <= narrow ? mem[portBOut] : mem[{portBOut[7:1], 1'b0}];
         portBIn <= mem[{portBOut[7:1], 1'b1}];
      end else if (cnt > 0) begin
         cnt <= cnt - 1;
         if (cnt == 1) begin
            portAIn <= ~portAIn;
            portBIn <= ~portBIn;
            if (!extRead && !portADriveN && narrow) begin
               mem[a] <= portAOut;
            end else if (!extRead && !portADriveN) begin
               mem[{a[7:1], 1'b0}] <= portAOut;
               mem[{a[7:1], 1'b1}] <= portBOut;
            end
         end
      end
   end
endmodule : ext_mem_model
`default_nettype wire

/* tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
   import op_mode_pkg::*;
   localparam int DC = 3;
   localparam logic [9:0] OFF = OPMODE_CTRL_OFFSET;
   logic clock, srst, dbg, hi, lo, regWr, regRd, accValid, accReady, accDone;
   logic enCmd, actCmd, exitCmd, portADriveN, portBDriveN, addrPhase, extRead;
   logic cpuActive, protectRelaxed, bgDebugEnabled, bgDebugActive, singleChip;
   logic narrowBus, wideBus, peripheralMode, portAbInMap, portEInMap, portKInMap;
   logic eClock, extBusStopInWait;
   logic [9:0] regAddr;
   logic [7:0] regWrData, regRdData, portAIn, portBIn, portAOut, portBOut;
   logic [15:0] accRdData;
   ext_req_t accReq;
   int bad_count = 0;
   int num_checks = 0;
   operating_mode_select #(.DATA_CYCLES(DC)) operating_mode_select_i (
      .clock(clock), .srst(srst), .debugStrapPin(dbg), .modeSelectHiPin(hi),
      .modeSelectLoPin(lo), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
      .regRd(regRd), .regRdData(regRdData), .bgDebugEnableCmd(enCmd),
      .bgDebugActivateCmd(actCmd), .bgDebugExitCmd(exitCmd), .accReq(accReq),
      .accValid(accValid), .accReady(accReady), .accDone(accDone),
      .accRdData(accRdData), .portAIn(portAIn), .portBIn(portBIn),
      .portAOut(portAOut), .portBOut(portBOut), .portADriveN(portADriveN),
      .portBDriveN(portBDriveN), .addrPhase(addrPhase), .extRead(extRead),
      .eClock(eClock), .cpuActive(cpuActive), .protectRelaxed(protectRelaxed),
      .bgDebugEnabled(bgDebugEnabled), .bgDebugActive(bgDebugActive),
      .singleChip(singleChip), .narrowBus(narrowBus), .wideBus(wideBus),
      .peripheralMode(peripheralMode), .portAbInMap(portAbInMap),
      .portEInMap(portEInMap), .portKInMap(portKInMap),
      .extBusStopInWait(extBusStopInWait));
   ext_mem_model #(.DC(DC)) ext_mem_model_i (
      .clock(clock), .narrow(narrowBus), .addrPhase(addrPhase), .extRead(extRead),
      .portADriveN(portADriveN), .portAOut(portAOut), .portBOut(portBOut),
      .portAIn(portAIn), .portBIn(portBIn));
   always #12.5 clock = ~clock;
   function automatic logic [7:0] mv(input logic [7:0] i);
      return i ^ 8'h5a;
   endfunction : mv
   task automatic stop_test;
      $display("checks=%0d errors=%0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : stop_test
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   task automatic check_bit(input logic got, input logic exp);
      check({15'h0000, got}, {15'h0000, exp});
   endtask : check_bit
   task automatic bound(input int k);
      if (k >= 40) begin
         bad_count++;
         $display("Error t=%0t wait=%h limit=%h", $time, k, 40);
         stop_test();
      end
   endtask : bound
   task automatic boot(input logic [2:0] s);
      {dbg, hi, lo} <= s;
      srst <= 1'b1;
      repeat (6) @(posedge clock);
      srst <= 1'b0;
      @(posedge clock);
   endtask : boot
   task automatic reg_wr(input logic [9:0] a, input logic [7:0] d);
      regAddr <= a;
      regWrData <= d;
      regWr <= 1'b1;
      @(posedge clock);
      regWr <= 1'b0;
      @(posedge clock);
   endtask : reg_wr
   task automatic reg_rd(input logic [9:0] a, output logic [15:0] d);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clock);
      regRd <= 1'b0;
      #1;
      d = {8'h00, regRdData};
      @(posedge clock);
   endtask : reg_rd
   task automatic acc(input ext_req_t r, input int n, output logic [15:0] d);
      int k;
      accReq <= r;
      accValid <= 1'b1;
      k = 0;
      #1;
      while (accReady !== 1'b1 && k < 40) begin
         @(posedge clock);
         #1;
         k++;
      end
      bound(k);
      @(posedge clock);
      accValid <= 1'b0;
      // Count from the accept edge; a no-bus done stands only one cycle
      k = 1;
      #1;
      check_bit(eClock, n > 1);
      while (accDone !== 1'b1 && k < 40) begin
         @(posedge clock);
         #1;
         k++;
      end
      bound(k);
      check(16'(k), 16'(n));
      d = accRdData;
      @(posedge clock);
   endtask : acc
   task automatic cmd(input logic [2:0] c);
      {enCmd, actCmd, exitCmd} <= c;
      @(posedge clock);
      {enCmd, actCmd, exitCmd} <= 3'h0;
      @(posedge clock);
      #1;
   endtask : cmd
   task automatic t_straps;
      logic [15:0] d;
      logic [7:0] e;
      logic [2:0] s;
      logic p;
      for (int i = 0; i < 8; i++) begin
         s = 3'(i);
         p = (s[1:0] == SEL_PERIPH);
         boot(s);
         e = {s[2], (s == STRAP_RESERVED) ? SEL_PERIPH : s[1:0],
              s[2] ? OPT_RESET_NORMAL : OPT_RESET_SPECIAL};
         reg_rd(OFF, d);
         check(d, p ? 16'h0000 : {8'h00, e});
         check_bit(peripheralMode, p);
         check_bit(cpuActive, !p);
         check_bit(singleChip, s[1:0] == SEL_SINGLE);
         check_bit(narrowBus, s[1:0] == SEL_NARROW);
         check_bit(wideBus, s[1:0] == SEL_WIDE);
         check_bit(bgDebugActive, s == STRAP_SPECIAL_SINGLE);
         check_bit(protectRelaxed, !(s[2] && !p));
         check_bit(portAbInMap, s[1:0] == SEL_SINGLE);
         check_bit(portEInMap, s[1:0] == SEL_SINGLE || (s[2] && !p));
         check_bit(portKInMap, s[1:0] == SEL_SINGLE || (s[2] && !p));
      end
   endtask : t_straps
   task automatic t_writes;
      logic [15:0] d;
      logic e;
      boot(STRAP_SPECIAL_SINGLE);
      // First write only lands in the stretch bit, which clears
      reg_wr(OFF, 8'h20);
      reg_rd(OFF, d);
      check(d, 16'h000b);
      #1;
      e = eClock;
      @(posedge clock);
      #1;
      check_bit(eClock, !e);
      reg_wr(OFF, 8'h3b);
      reg_rd(OFF, d);
      check(d, 16'h003b);
      check_bit(narrowBus, 1'b1);
      // Select code 10 and the stop-in-wait bit must both be dropped
      reg_wr(OFF, 8'h5f);
      reg_rd(OFF, d);
      check(d, 16'h003b);
      reg_wr(10'(OFF + 1), 8'hff);
      reg_rd(10'(OFF + 1), d);
      check(d, 16'h0000);
      boot(3'h4);
      reg_wr(OFF, 8'h74);
      reg_rd(OFF, d);
      check(d, 16'h00f4);
      check_bit(extBusStopInWait, 1'b1);
      reg_wr(OFF, 8'h00);
      reg_rd(OFF, d);
      check(d, 16'h00f0);
      check_bit(extBusStopInWait, 1'b0);
   endtask : t_writes
   task automatic t_bus;
      logic [15:0] d;
      boot(3'h1);
      acc('{16'h1234, 16'h0000, 1'b0, 1'b1, 1'b0}, 2 * (1 + DC) + 1, d);
      check(d, {mv(8'h34), mv(8'h35)});
      acc('{16'h0010, 16'hbeef, 1'b1, 1'b1, 1'b0}, 2 * (1 + DC) + 1, d);
      acc('{16'h0010, 16'h0000, 1'b0, 1'b1, 1'b0}, 2 * (1 + DC) + 1, d);
      check(d, 16'hbeef);
      // Visible internal read runs one wide beat and captures nothing
      acc('{16'h0050, 16'h0000, 1'b0, 1'b1, 1'b1}, 2 + DC, d);
      check(d, 16'hbeef);
      boot(3'h7);
      acc('{16'h2040, 16'h0000, 1'b0, 1'b1, 1'b0}, 2 + DC, d);
      check(d, {mv(8'h40), mv(8'h41)});
      acc('{16'h0050, 16'h0000, 1'b0, 1'b1, 1'b1}, 1, d);
      check(d, {mv(8'h40), mv(8'h41)});
      boot(3'h4);
      acc('{16'h1234, 16'h0000, 1'b0, 1'b1, 1'b0}, 1, d);
      check_bit(portADriveN, 1'b1);
      check_bit(portBDriveN, 1'b1);
   endtask : t_bus
   task automatic t_periph;
      logic [15:0] d;
      // No debug pulses while in this mode
      boot(3'h2);
      #1;
      check_bit(accReady, 1'b0);
      reg_wr(OFF, 8'h60);
      reg_rd(OFF, d);
      check(d, 16'h0000);
      check_bit(peripheralMode, 1'b1);
   endtask : t_periph
   task automatic t_debug;
      boot(3'h4);
      cmd(3'h2);
      check_bit(bgDebugActive, 1'b0);
      cmd(3'h4);
      check_bit(bgDebugEnabled, 1'b1);
      cmd(3'h2);
      check_bit(bgDebugActive, 1'b1);
      cmd(3'h1);
      check_bit(bgDebugActive, 1'b0);
   endtask : t_debug
   initial begin
      clock = 1'b0;
      srst = 1'b1;
      {dbg, hi, lo} = 3'h4;
      {regWr, regRd, accValid, enCmd, actCmd, exitCmd} = 6'h00;
      regAddr = 10'h000;
      regWrData = 8'h00;
      accReq = '0;
      t_straps();
      t_writes();
      t_bus();
      t_periph();
      t_debug();
      stop_test();
   end
endmodule : tb
`default_nettype wire
